// ===== logic/isf_pkg.sv
package isf_pkg;

   localparam int ADDR_W = 8;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_TXBUF = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_RXHOLD = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h14;

   // status word bit positions
   localparam int ST_NACK = 15;
   localparam int ST_MTX = 14;
   localparam int ST_ACKWIN = 13;
   localparam int ST_BCL = 10;
   localparam int ST_GCALL = 9;
   localparam int ST_TENBIT = 8;
   localparam int ST_WCOL = 7;
   localparam int ST_OVF = 6;
   localparam int ST_DATA = 5;
   localparam int ST_RXFULL = 0;

   // control word bit positions
   localparam int CT_OWN_LO = 0;
   localparam int CT_TEN_EN = 10;
   localparam int CT_SCD_EN = 11;
   localparam int CT_MASTER = 12;

   // interrupt event bit positions
   localparam int EV_BCL = 0;
   localparam int EV_WCOL = 1;
   localparam int EV_OVF = 2;
   localparam int EV_ACKWIN = 3;
   localparam int EV_STOP = 4;
   localparam int EV_W = 5;

   // reset values and codes
   localparam logic [15:0] STATUS_RST = 16'h0000;
   localparam logic [12:0] CTRL_RST = 13'h0000;
   localparam logic [EV_W-1:0] EV_RST = 5'h00;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [7:0] GCALL_ADDR = 8'h00;
   localparam logic [4:0] TEN_BIT_HDR = 5'h1e;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== logic/isf_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module isf_pin_sync (
   input wire logic clock,
   input wire logic resetn,
   input wire logic pin,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta_r;
   logic sync_r;
   logic last_r;

   // first stage feeds only the second stage
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
         last_r <= 1'b1;
      end else begin
         meta_r <= pin;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   assign level = sync_r;
   assign rise = sync_r & ~last_r;
   assign fall = ~sync_r & last_r;
endmodule
`default_nettype wire

// ===== logic/isf_status_flags.sv
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - master tx: ack result flag, 1 means nack
// - master tx flag spans 8 bits plus ack
// - slave ack window: 8th fall to 9th rise
// - status bits 12 and 11 read zero
// - master collision sets sticky collision flag
// - general call flag set on match, stop clears
// - ten-bit match on second byte, stop clears
// - tx write while busy dropped, flags collision
// - transfer into full holding sets overflow
// - data flag: clear on own address match, set on data
// - slave collision detect: flag and go idle
module isf_status_flags
   import isf_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic [isf_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [isf_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic scl_pin,
   input wire logic sda_pin,
   input wire logic slave_tx_active,
   input wire logic slave_sda_high,
   output logic tx_load,
   output logic [7:0] tx_byte,
   output logic bus_idle,
   output logic irq
);
   import isf_pkg::*;

   logic scl;
   logic scl_rise;
   logic scl_fall;
   logic sda;
   logic sda_rise;
   logic sda_fall;

   isf_pin_sync u_scl (
      .clock(clock),
      .resetn(resetn),
      .pin(scl_pin),
      .level(scl),
      .rise(scl_rise),
      .fall(scl_fall)
   );

   isf_pin_sync u_sda (
      .clock(clock),
      .resetn(resetn),
      .pin(sda_pin),
      .level(sda),
      .rise(sda_rise),
      .fall(sda_fall)
   );

   // control and flag state
   logic [12:0] ctrl_r;
   logic nack_received_flag_r;
   logic master_tx_in_progress_r;
   logic ack_window_flag_r;
   logic bus_collision_flag_r;
   logic general_call_flag_r;
   logic ten_bit_addr_match_r;
   logic tx_write_collision_r;
   logic rx_overflow_flag_r;
   logic data_flag_r;
   logic rx_full_r;
   logic [7:0] tx_buffer_reg_r;
   logic [7:0] tx_shift_r;
   logic [7:0] rx_shift_reg_r;
   logic [7:0] rx_holding_reg_r;
   logic [EV_W-1:0] ev_stat_r;
   logic [EV_W-1:0] ev_mask_r;

   // bus tracker state
   logic active_r;
   logic [3:0] bits_r;
   logic [1:0] byte_idx_r;
   logic addressed_r;
   logic ten_pending_r;

   // axi write side
   logic aw_held_r;
   logic w_held_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic wr_do;
   logic rd_do;

   logic start_det;
   logic stop_det;
   logic bit_edge;
   logic ack_edge;
   logic [7:0] byte_in;
   logic byte_done;
   logic slave_mode;
   logic own_match;
   logic gcall_match;
   logic ten_hdr;
   logic ten_low_match;
   logic coll_master;
   logic coll_slave;
   logic busy;
   logic tx_wr;
   logic rx_rd;
   logic xfer;
   logic [15:0] status_word;
   logic [EV_W-1:0] ev_set;
   logic [EV_W-1:0] ev_clr;

   assign slave_mode = ~ctrl_r[CT_MASTER];
   assign start_det = sda_fall & scl;
   assign stop_det = sda_rise & scl;
   assign bit_edge = active_r & scl_rise & (bits_r < BITS_PER_BYTE);
   assign ack_edge = active_r & scl_rise & (bits_r == BITS_PER_BYTE);
   assign byte_in = {rx_shift_reg_r[6:0], sda};
   assign byte_done = bit_edge & (bits_r == BITS_PER_BYTE - 4'h1);
   assign gcall_match = byte_in == GCALL_ADDR;
   assign ten_hdr = byte_in[7:3] == TEN_BIT_HDR;
   assign own_match = ctrl_r[CT_TEN_EN]
      ? (ten_hdr & (byte_in[2:1] == ctrl_r[9:8]))
      : (byte_in[7:1] == ctrl_r[6:0]);
   assign ten_low_match = byte_in == ctrl_r[7:0];
   // sampled low while we meant high on the rising edge
   assign coll_master = ctrl_r[CT_MASTER] & master_tx_in_progress_r
      & bit_edge & tx_shift_r[7] & ~sda;
   assign coll_slave = slave_mode & ctrl_r[CT_SCD_EN] & slave_tx_active
      & active_r & scl_rise & slave_sda_high & ~sda;
   assign busy = master_tx_in_progress_r | (slave_mode & slave_tx_active);
   assign tx_wr = wr_do & (awaddr_r == OFS_TXBUF) & wstrb_r[0];
   assign rx_rd = rd_do & (s_axi_araddr == OFS_RXHOLD);
   assign xfer = slave_mode & byte_done & (addressed_r | byte_idx_r == 2'h0);

   // tracker: start, stop, bit and byte counting
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         active_r <= 1'b0;
         bits_r <= 4'h0;
         byte_idx_r <= 2'h0;
      end else if (coll_slave | coll_master) begin
         active_r <= 1'b0;
         bits_r <= 4'h0;
      end else if (start_det) begin
         active_r <= 1'b1;
         bits_r <= 4'h0;
         byte_idx_r <= 2'h0;
      end else if (stop_det) begin
         active_r <= 1'b0;
         bits_r <= 4'h0;
      end else if (bit_edge) begin
         bits_r <= bits_r + 4'h1;
      end else if (ack_edge) begin
         bits_r <= 4'h0;
         if (byte_idx_r != 2'h3) begin
            byte_idx_r <= byte_idx_r + 2'h1;
         end
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rx_shift_reg_r <= BYTE_RST;
      end else if (bit_edge) begin
         rx_shift_reg_r <= byte_in;
      end
   end

   // addressing; ten-bit waits for the second byte
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         addressed_r <= 1'b0;
         ten_pending_r <= 1'b0;
      end else if (start_det | stop_det | coll_slave) begin
         addressed_r <= 1'b0;
         ten_pending_r <= 1'b0;
      end else if (slave_mode & byte_done & byte_idx_r == 2'h0) begin
         ten_pending_r <= ctrl_r[CT_TEN_EN] & own_match;
         addressed_r <= (~ctrl_r[CT_TEN_EN] & own_match) | gcall_match;
      end else if (byte_done & ten_pending_r & byte_idx_r == 2'h1) begin
         ten_pending_r <= 1'b0;
         addressed_r <= ten_low_match;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         general_call_flag_r <= 1'b0;
      end else if (slave_mode & byte_done & byte_idx_r == 2'h0
                   & gcall_match) begin
         general_call_flag_r <= 1'b1;
      end else if (stop_det) begin
         general_call_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ten_bit_addr_match_r <= 1'b0;
      end else if (byte_done & ten_pending_r & byte_idx_r == 2'h1
                   & ten_low_match) begin
         ten_bit_addr_match_r <= 1'b1;
      end else if (stop_det) begin
         ten_bit_addr_match_r <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         data_flag_r <= 1'b0;
      end else if (slave_mode & byte_done) begin
         if (byte_idx_r == 2'h0 & own_match & ~ctrl_r[CT_TEN_EN]) begin
            data_flag_r <= 1'b0;
         end else if (byte_idx_r == 2'h1 & ten_pending_r) begin
            data_flag_r <= ~ten_low_match;
         end else if (addressed_r) begin
            data_flag_r <= 1'b1;
         end
      end
   end

   // eighth falling edge opens the window, ninth rising closes it
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ack_window_flag_r <= 1'b0;
      end else if (~slave_mode | ~active_r | ack_edge) begin
         ack_window_flag_r <= 1'b0;
      end else if (scl_fall & bits_r == BITS_PER_BYTE) begin
         ack_window_flag_r <= 1'b1;
      end
   end

   // master transmit: tx byte is shifted against the bus for collisions
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         master_tx_in_progress_r <= 1'b0;
         tx_shift_r <= BYTE_RST;
      end else if (coll_master) begin
         master_tx_in_progress_r <= 1'b0;
      end else if (tx_wr & ~busy & ctrl_r[CT_MASTER]) begin
         master_tx_in_progress_r <= 1'b1;
         tx_shift_r <= wdata_r[7:0];
      end else if (master_tx_in_progress_r & ack_edge) begin
         master_tx_in_progress_r <= 1'b0;
      end else if (master_tx_in_progress_r & bit_edge) begin
         tx_shift_r <= {tx_shift_r[6:0], 1'b0};
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         nack_received_flag_r <= 1'b0;
      end else if (master_tx_in_progress_r & ack_edge) begin
         nack_received_flag_r <= sda;
      end
   end

   // a write while busy never reaches the buffer
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         tx_buffer_reg_r <= BYTE_RST;
         tx_load <= 1'b0;
         tx_byte <= BYTE_RST;
      end else begin
         tx_load <= tx_wr & ~busy;
         if (tx_wr & ~busy) begin
            tx_buffer_reg_r <= wdata_r[7:0];
            tx_byte <= wdata_r[7:0];
         end
      end
   end

   // sticky flags: hardware set wins over a write-one clear
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         bus_collision_flag_r <= 1'b0;
      end else if (coll_master | coll_slave) begin
         bus_collision_flag_r <= 1'b1;
      end else if (wr_do & awaddr_r == OFS_STATUS & wstrb_r[1]
                   & wdata_r[ST_BCL]) begin
         bus_collision_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         tx_write_collision_r <= 1'b0;
      end else if (tx_wr & busy) begin
         tx_write_collision_r <= 1'b1;
      end else if (wr_do & awaddr_r == OFS_STATUS & wstrb_r[0]
                   & wdata_r[ST_WCOL]) begin
         tx_write_collision_r <= 1'b0;
      end
   end

   // holding register keeps the old byte when full
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rx_overflow_flag_r <= 1'b0;
      end else if (xfer & rx_full_r) begin
         rx_overflow_flag_r <= 1'b1;
      end else if (wr_do & awaddr_r == OFS_STATUS & wstrb_r[0]
                   & wdata_r[ST_OVF]) begin
         rx_overflow_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rx_full_r <= 1'b0;
         rx_holding_reg_r <= BYTE_RST;
      end else if (xfer & ~rx_full_r) begin
         rx_full_r <= 1'b1;
         rx_holding_reg_r <= byte_in;
      end else if (rx_rd) begin
         rx_full_r <= 1'b0;
      end
   end

   // control: own address, ten-bit, slave collision enable, master
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ctrl_r <= CTRL_RST;
      end else if (wr_do & awaddr_r == OFS_CTRL) begin
         if (wstrb_r[0]) begin
            ctrl_r[7:0] <= wdata_r[7:0];
         end
         if (wstrb_r[1]) begin
            ctrl_r[12:8] <= wdata_r[12:8];
         end
      end
   end

   // unused bits 12 and 11 and the spare low bits stay zero
   assign status_word = {nack_received_flag_r, master_tx_in_progress_r,
      ack_window_flag_r, 2'b00, bus_collision_flag_r, general_call_flag_r,
      ten_bit_addr_match_r, tx_write_collision_r, rx_overflow_flag_r,
      data_flag_r, 4'h0, rx_full_r};

   // interrupt events
   assign ev_set[EV_BCL] = coll_master | coll_slave;
   assign ev_set[EV_WCOL] = tx_wr & busy;
   assign ev_set[EV_OVF] = xfer & rx_full_r;
   assign ev_set[EV_ACKWIN] = slave_mode & active_r & scl_fall
      & bits_r == BITS_PER_BYTE & ~ack_window_flag_r;
   assign ev_set[EV_STOP] = stop_det;
   assign ev_clr = (wr_do & awaddr_r == OFS_IRQ_STAT & wstrb_r[0])
      ? wdata_r[EV_W-1:0] : EV_RST;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ev_stat_r <= EV_RST;
      end else begin
         ev_stat_r <= (ev_stat_r & ~ev_clr) | ev_set;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ev_mask_r <= EV_RST;
      end else if (wr_do & awaddr_r == OFS_IRQ_MASK & wstrb_r[0]) begin
         ev_mask_r <= wdata_r[EV_W-1:0];
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         irq <= 1'b0;
         bus_idle <= 1'b1;
      end else begin
         irq <= |(ev_stat_r & ev_mask_r);
         bus_idle <= ~active_r;
      end
   end

   // axi write: address and data taken in either order
   assign wr_do = aw_held_r & w_held_r & ~s_axi_bvalid;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= ~aw_held_r & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready <= ~w_held_r & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end else if (wr_do) begin
            aw_held_r <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end else if (wr_do) begin
            w_held_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_do) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (awaddr_r == OFS_STATUS | awaddr_r == OFS_CTRL
            | awaddr_r == OFS_TXBUF | awaddr_r == OFS_IRQ_STAT
            | awaddr_r == OFS_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // axi read: one cycle to answer, reading the holding reg empties it
   assign rd_do = s_axi_arvalid & s_axi_arready;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
         if (rd_do) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (s_axi_araddr)
               OFS_STATUS: s_axi_rdata <= {16'h0000, status_word};
               OFS_CTRL: s_axi_rdata <= {19'h00000, ctrl_r};
               OFS_TXBUF: s_axi_rdata <= {24'h000000, tx_buffer_reg_r};
               OFS_RXHOLD: s_axi_rdata <= {24'h000000, rx_holding_reg_r};
               OFS_IRQ_STAT: s_axi_rdata <= {27'h0000000, ev_stat_r};
               OFS_IRQ_MASK: s_axi_rdata <= {27'h0000000, ev_mask_r};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ===== sim/isf_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
// far-side bus party; drives both lines itself, so a released line is driven to 1
// scl stands still between frames; 80 ns per bit
module isf_bus_model (
   output logic scl,
   output logic sda
);
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // also a repeated start from scl low
   task automatic start();
      #3;
      scl = 1'b1;
      #20;
      sda = 1'b0;
      #40;
      scl = 1'b0;
      #20;
   endtask
   task automatic bits(input logic [7:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         sda = b[7-i];
         #20;
         scl = 1'b1;
         #40;
         scl = 1'b0;
         #20;
      end
      sda = 1'b1;
   endtask
   task automatic stop();
      sda = 1'b0;
      #20;
      scl = 1'b1;
      #20;
      sda = 1'b1;
      #40;
   endtask
endmodule
`default_nettype wire

// ===== sim/isf_status_flags_chk.sv
`timescale 1ns/100ps
`default_nettype none
module isf_status_flags_chk
   import isf_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic [isf_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [isf_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic tx_load,
   input wire logic [7:0] tx_byte,
   input wire logic irq
);
   logic [ADDR_W-1:0] ra_r;
   logic [ADDR_W-1:0] wa_r;
   logic rd_bad;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) ra_r <= '0;
      else if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) wa_r <= '0;
      else if (s_axi_awvalid && s_axi_awready) wa_r <= s_axi_awaddr;
   end
   // misaligned offsets count as unmapped too
   assign rd_bad = (ra_r > OFS_IRQ_MASK) || (ra_r[1:0] != 2'h0);
   property p_rd_lat;
      (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   property p_rd_hold;
      (s_axi_rvalid && !s_axi_rready)
         |=> (s_axi_rvalid && $stable(s_axi_rdata));
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
   property p_wr_lat;
      (s_axi_awready && s_axi_wready) |-> ##[1:3] s_axi_bvalid;
   endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
   property p_b_hold;
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid;
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_st_zero;
      (s_axi_rvalid && ra_r == OFS_STATUS) |-> (s_axi_rdata[12:11] == 2'h0
         && s_axi_rdata[4:1] == 4'h0 && s_axi_rdata[31:16] == 16'h0);
   endproperty
   a_st_zero: assert property (p_st_zero)
      else $error("unused bits set");
   property p_rd_err;
      (s_axi_rvalid && rd_bad) |-> (s_axi_rresp == RESP_SLVERR
         && s_axi_rdata == 32'h0);
   endproperty
   a_rd_err: assert property (p_rd_err) else $error("unmapped read ok");
   property p_wr_ro;
      (s_axi_bvalid && wa_r == OFS_RXHOLD) |-> s_axi_bresp == RESP_SLVERR;
   endproperty
   a_wr_ro: assert property (p_wr_ro)
      else $error("rx write accepted");
   property p_tx_hold;
      tx_load |=> (!tx_load && $stable(tx_byte)) [*3];
   endproperty
   a_tx_hold: assert property (p_tx_hold)
      else $error("tx byte moved");
   c_load: cover property (tx_load);
   c_irq: cover property ($rose(irq));
   c_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
bind isf_status_flags isf_status_flags_chk isf_status_flags_chk_i (
   .clock, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready, .tx_load, .tx_byte, .irq);
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import isf_pkg::*;
   localparam logic [15:0] NK = 16'h1 << ST_NACK, MT = 16'h1 << ST_MTX,
      AW = 16'h1 << ST_ACKWIN, BC = 16'h1 << ST_BCL, GC = 16'h1 << ST_GCALL,
      TB = 16'h1 << ST_TENBIT, WC = 16'h1 << ST_WCOL, OV = 16'h1 << ST_OVF,
      DA = 16'h1 << ST_DATA, RF = 16'h1 << ST_RXFULL;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, sta = 1'b0, shi = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, tx_load, bus_idle, irq;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d;
   logic [7:0] tx_byte, last_byte;
   wire scl;
   wire sda;
   int err_count = 0, checked = 0, loads = 0;
   always #4 clock = ~clock;
   isf_bus_model bus_i (.scl(scl), .sda(sda));
   isf_status_flags isf_status_flags_i (.clock(clock), .resetn(resetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .scl_pin(scl), .sda_pin(sda),
      .slave_tx_active(sta), .slave_sda_high(shi), .tx_load(tx_load),
      .tx_byte(tx_byte), .bus_idle(bus_idle), .irq(irq));
   // falling edge: the pulse has settled, no race with the task's compare
   always @(negedge clock) begin
      if (tx_load === 1'b1) begin
         loads++;
         last_byte = tx_byte;
      end
   end
   task automatic finish_test();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic ck(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
      input logic [1:0] er);
      logic done;
      done = 1'b0;
      @(posedge clock);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge clock);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            done = 1'b1;
            r = bresp;
            bready <= 1'b0;
         end
      end
      ck({30'h0, r}, {30'h0, er});
   endtask
   task automatic rd(input logic [7:0] a);
      logic done;
      done = 1'b0;
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge clock);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            done = 1'b1;
            d = rdata;
            r = rresp;
            rready <= 1'b0;
         end
      end
   endtask
   task automatic st(input logic [15:0] m, input logic [15:0] e);
      rd(OFS_STATUS);
      ck(d & {16'h0, m}, {16'h0, e});
   endtask
   // start after a stop so each case sees a fresh address byte
   task automatic addr(input logic [7:0] b);
      bus_i.start();
      bus_i.bits(b, 8);
      bus_i.bits(8'h00, 1);
   endtask
   initial begin
      repeat (20) @(posedge clock);
      resetn <= 1'b1;
      for (int a = 0; a <= 24; a += 4) begin
         rd(8'(a));
         ck(d, 32'h0);
         ck({30'h0, r}, {30'h0, (a == 24) ? RESP_SLVERR : RESP_OKAY});
      end
      wr(OFS_STATUS, 32'hffff, RESP_OKAY);
      st(16'hffff, 16'h0);
      wr(OFS_RXHOLD, 32'h1, RESP_SLVERR);
      wr(OFS_CTRL, 32'h082a, RESP_OKAY);
      rd(OFS_CTRL);
      ck(d, 32'h082a);
      bus_i.start();
      bus_i.bits(8'h54, 8);
      st(AW, AW);
      bus_i.bits(8'h00, 1);
      st(AW | DA | RF, RF);
      bus_i.bits(8'h3c, 8);
      bus_i.bits(8'h00, 1);
      st(DA | OV | RF, DA | OV | RF);
      rd(OFS_IRQ_STAT);
      ck(d, (32'h1 << EV_OVF) | (32'h1 << EV_ACKWIN));
      ck({31'h0, irq}, 32'h0);
      wr(OFS_IRQ_MASK, 32'h1 << EV_OVF, RESP_OKAY);
      repeat (2) @(posedge clock);
      ck({31'h0, irq}, 32'h1);
      wr(OFS_IRQ_STAT, 32'h1f, RESP_OKAY);
      repeat (2) @(posedge clock);
      ck({31'h0, irq}, 32'h0);
      rd(OFS_RXHOLD);
      ck(d, 32'h54);
      wr(OFS_STATUS, {16'h0, OV}, RESP_OKAY);
      st(OV | RF, 16'h0);
      bus_i.stop();
      ck({31'h0, bus_idle}, 32'h1);
      addr(8'h00);
      st(GC, GC);
      bus_i.stop();
      st(GC, 16'h0);
      wr(OFS_CTRL, 32'h06a5, RESP_OKAY);
      addr(8'hf4);
      bus_i.bits(8'ha5, 8);
      bus_i.bits(8'h00, 1);
      st(TB | DA, TB);
      bus_i.stop();
      st(TB, 16'h0);
      wr(OFS_CTRL, 32'h082a, RESP_OKAY);
      addr(8'h55);
      @(posedge clock);
      sta <= 1'b1;
      shi <= 1'b1;
      wr(OFS_TXBUF, 32'h11, RESP_OKAY);
      ck(32'(loads), 32'h0);
      st(WC, WC);
      bus_i.bits(8'h00, 1);
      st(BC, BC);
      ck({31'h0, bus_idle}, 32'h1);
      @(posedge clock);
      sta <= 1'b0;
      shi <= 1'b0;
      bus_i.stop();
      wr(OFS_STATUS, {16'h0, BC | WC}, RESP_OKAY);
      st(BC | WC, 16'h0);
      wr(OFS_CTRL, 32'h1000, RESP_OKAY);
      wr(OFS_TXBUF, 32'ha5, RESP_OKAY);
      ck(32'(loads), 32'h1);
      ck({24'h0, last_byte}, 32'ha5);
      st(MT, MT);
      wr(OFS_TXBUF, 32'h5a, RESP_OKAY);
      ck(32'(loads), 32'h1);
      st(WC, WC);
      bus_i.start();
      bus_i.bits(8'ha5, 8);
      st(MT, MT);
      bus_i.bits(8'h80, 1);
      st(MT | NK, NK);
      wr(OFS_TXBUF, 32'h3c, RESP_OKAY);
      bus_i.bits(8'h3c, 8);
      bus_i.bits(8'h00, 1);
      st(MT | NK, 16'h0);
      wr(OFS_TXBUF, 32'h80, RESP_OKAY);
      bus_i.bits(8'h00, 1);
      st(BC, BC);
      ck({31'h0, bus_idle}, 32'h1);
      bus_i.stop();
      finish_test();
   end
   // run needs about 8.5 us; a hang is cut well past that
   initial begin
      #300000;
      err_count++;
      finish_test();
   end
endmodule
`default_nettype wire
